/* File: logic/fptx_core.sv */
`timescale 1ns/100ps
`default_nettype none
module fptx_core (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [5:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic             wb_ack_out,
  output logic      [31:0] wb_dat_out
);
  // ==========================================================
  // Helpers
  // Byte swap of the memory image, word or doubleword wide
  function automatic logic [63:0] swap(input logic [63:0] x, input logic dbl);
    logic [63:0] y;
    y = 64'h0;
    for (int i = 0; i < 8; i++) begin
      if (dbl) y[8*i +: 8] = x[8*(7-i) +: 8];
      else if (i < 4) y[8*i +: 8] = x[8*(3-i) +: 8];
    end
    return y;
  endfunction : swap

  // Memory format to 82-bit register format
  function automatic logic [81:0] to_reg(input logic [63:0] m, input logic dbl);
    logic        s;
    logic [10:0] e;
    logic [51:0] f;
    logic [10:0] emax;
    logic [16:0] adj;
    s    = dbl ? m[63] : m[31];
    e    = dbl ? m[62:52] : {3'h0, m[30:23]};
    f    = dbl ? m[51:0] : {m[22:0], 29'h0};
    emax = dbl ? 11'h7ff : 11'h0ff;
    adj  = dbl ? fptx_pkg::ADJ_DBL : fptx_pkg::ADJ_SGL;
    if (e == 11'h0 && f == 52'h0) return {s, 17'h0, 64'h0};
    else if (e == emax) return {s, fptx_pkg::EXP_INF, 1'b1, f, 11'h0};
    else if (e == 11'h0) return {s, 17'(adj + 17'h1), 1'b0, f, 11'h0};
    else return {s, 17'(adj + {6'h0, e}), 1'b1, f, 11'h0};
  endfunction : to_reg

  // Register format back to memory format; no range clamping
  function automatic logic [63:0] to_mem(input logic [81:0] r, input logic dbl);
    logic [10:0] e;
    logic [16:0] adj;
    adj = dbl ? fptx_pkg::ADJ_DBL : fptx_pkg::ADJ_SGL;
    if (r[80:64] == fptx_pkg::EXP_INF) e = 11'h7ff;
    else if (!r[63]) e = 11'h0;
    else e = 11'(r[80:64] - adj);
    if (dbl) return {r[81], e, r[62:11]};
    else return {32'h0, r[81], e[7:0], r[62:40]};
  endfunction : to_mem

  // ==========================================================
  // Bus slave state
  logic        ack, next_ack;             // Registered acknowledge
  logic [31:0] rdat, next_rdat;           // Registered read data
  logic        wr_hit;                    // Write takes effect now
  // Software registers
  logic [31:0] ctrl, next_ctrl;           // Operation word
  logic [63:0] gr, next_gr;               // General register operand
  logic        gr_tok, next_gr_tok;       // Its deferred_exception_bit
  logic [81:0] fr, next_fr;               // Floating register operand
  logic [31:0] sf, next_sf;               // Four status fields
  logic [5:0]  traps, next_traps;         // Global trap disables
  logic [23:0] flags, next_flags;         // Four flag groups
  logic [23:0] flag_clr;                  // Write-one-to-clear mask
  // Execution results
  logic        go, next_go;               // Launch pulse
  logic [81:0] res, next_res;             // Register-format result
  logic [63:0] rgr, next_rgr;             // General-format result
  logic        rtok, next_rtok;           // Result token bit
  logic [15:0] opst, next_opst;           // Control actually applied
  logic [23:0] flag_set;                  // Flags raised by this op

  assign wr_hit   = wb_cyc_in & wb_stb_in & wb_we_in & ack;
  assign flag_clr = (wr_hit && wb_adr_in == fptx_pkg::ADR_FLAGS && wb_sel_in[0])
                    ? wb_dat_in[23:0] : 24'h0;

  // ==========================================================
  // Bus slave: one wait state, ack drops after one cycle
  always_comb begin
    next_ack  = wb_cyc_in & wb_stb_in & ~ack;
    next_rdat = 32'h0;                    // Unmapped reads give zero
    unique case (wb_adr_in)
      fptx_pkg::ADR_CTRL:   next_rdat = ctrl;
      fptx_pkg::ADR_GR_LO:  next_rdat = gr[31:0];
      fptx_pkg::ADR_GR_HI:  next_rdat = gr[63:32];
      fptx_pkg::ADR_FR_LO:  next_rdat = fr[31:0];
      fptx_pkg::ADR_FR_HI:  next_rdat = fr[63:32];
      fptx_pkg::ADR_FR_SE:  next_rdat = {13'h0, gr_tok, fr[81:64]};
      fptx_pkg::ADR_SF:     next_rdat = sf;
      fptx_pkg::ADR_TRAPS:  next_rdat = {26'h0, traps};
      fptx_pkg::ADR_FLAGS:  next_rdat = {8'h0, flags};
      fptx_pkg::ADR_RES_LO: next_rdat = rgr[31:0];
      fptx_pkg::ADR_RES_HI: next_rdat = rgr[63:32];
      fptx_pkg::ADR_RES_SE: next_rdat = {13'h0, rtok, res[81:64]};
      fptx_pkg::ADR_OPSTAT: next_rdat = {16'h0, opst};
      default:              next_rdat = 32'h0;
    endcase
    if (!(wb_cyc_in && wb_stb_in && !ack)) next_rdat = 32'h0;
  end

  // Register the answer
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ack  <= 1'b0;
      rdat <= 32'h0;
    end else begin
      ack  <= next_ack;
      rdat <= next_rdat;
    end
  end
  assign wb_ack_out = ack;
  assign wb_dat_out = rdat;

  // ==========================================================
  // Software registers, byte lanes honoured
  always_comb begin
    logic [31:0] d;
    logic [31:0] m;
    d = wb_dat_in;
    m = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    next_ctrl   = ctrl;
    next_gr     = gr;
    next_gr_tok = gr_tok;
    next_fr     = fr;
    next_sf     = sf;
    next_traps  = traps;
    next_go     = 1'b0;
    if (wr_hit) begin
      unique case (wb_adr_in)
        fptx_pkg::ADR_CTRL: begin
          next_ctrl = (ctrl & ~m) | (d & m);
          next_ctrl[fptx_pkg::CTRL_GO_BIT] = 1'b0;   // Self-clearing
          next_go   = wb_sel_in[1] & d[fptx_pkg::CTRL_GO_BIT];
        end
        fptx_pkg::ADR_GR_LO: next_gr[31:0]  = (gr[31:0] & ~m) | (d & m);
        fptx_pkg::ADR_GR_HI: next_gr[63:32] = (gr[63:32] & ~m) | (d & m);
        fptx_pkg::ADR_FR_LO: next_fr[31:0]  = (fr[31:0] & ~m) | (d & m);
        fptx_pkg::ADR_FR_HI: next_fr[63:32] = (fr[63:32] & ~m) | (d & m);
        fptx_pkg::ADR_FR_SE: begin
          next_fr[81:64] = (fr[81:64] & ~m[17:0]) | (d[17:0] & m[17:0]);
          if (wb_sel_in[2]) next_gr_tok = d[18];
        end
        fptx_pkg::ADR_SF: begin
          next_sf = (sf & ~m) | (d & m);
          next_sf[fptx_pkg::SF_TD_BIT] = 1'b0;
        end
        fptx_pkg::ADR_TRAPS: if (wb_sel_in[0]) next_traps = d[5:0];
        default: ;
      endcase
    end
  end

  // Register the software state
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl   <= 32'h0;
      gr     <= 64'h0;
      gr_tok <= 1'b0;
      fr     <= 82'h0;
      sf     <= fptx_pkg::SF_RST;
      traps  <= fptx_pkg::TRAPS_RST;
      go     <= 1'b0;
    end else begin
      ctrl   <= next_ctrl;
      gr     <= next_gr;
      gr_tok <= next_gr_tok;
      fr     <= next_fr;
      sf     <= next_sf;
      traps  <= next_traps;
      go     <= next_go;
    end
  end

  // ==========================================================
  // Execution: transfers and status-field selection
  always_comb begin
    fptx_pkg::fptx_op_t op;
    logic [1:0]  sel, pcc, pr, ew, rc;
    logic [7:0]  fld;
    logic        be, par, arith, upd, bad;
    logic [63:0] img;
    img   = 64'h0;                                  // Memory image, idle when no launch
    op    = fptx_pkg::fptx_op_t'(ctrl[fptx_pkg::CTRL_OP_LSB +: 4]);
    sel   = ctrl[fptx_pkg::CTRL_SF_LSB +: 2];
    pcc   = ctrl[fptx_pkg::CTRL_PC_LSB +: 2];
    be    = ctrl[fptx_pkg::CTRL_BE_BIT];
    par   = ctrl[fptx_pkg::CTRL_PAR_BIT];
    fld   = sf[8*sel +: 8];
    rc    = fld[fptx_pkg::SF_RC_LSB +: 2];
    arith = op[3];
    upd   = arith && op != fptx_pkg::OP_CVT_XF;
    bad   = 1'b0;
    pr    = fptx_pkg::PR_EXT;
    ew    = fptx_pkg::EW_17;
    // Precision and exponent range
    if (par) begin
      pr = fptx_pkg::PR_SGL;                        // Single pair
      ew = fptx_pkg::EW_8;
      bad = (op == fptx_pkg::OP_CVT_XF);
    end else if (op == fptx_pkg::OP_FMA || op == fptx_pkg::OP_FMS ||
                 op == fptx_pkg::OP_FNMA) begin
      if (pcc == fptx_pkg::PC_SGL) begin
        pr = fptx_pkg::PR_SGL;
        ew = fld[fptx_pkg::SF_WRE_BIT] ? fptx_pkg::EW_17 : fptx_pkg::EW_8;
      end else if (pcc == fptx_pkg::PC_DBL) begin
        pr = fptx_pkg::PR_DBL;
        ew = fld[fptx_pkg::SF_WRE_BIT] ? fptx_pkg::EW_17 : fptx_pkg::EW_11;
      end else begin
        pr  = fld[fptx_pkg::SF_PC_LSB +: 2];
        ew  = fld[fptx_pkg::SF_WRE_BIT] ? fptx_pkg::EW_17 : fptx_pkg::EW_15;
        bad = (pr == fptx_pkg::PR_RSV);             // Reserved dynamic code
      end
    end                                             // Else full range
    // Truncating conversions ignore the field rounding mode
    if (op == fptx_pkg::OP_CVT_FX && ctrl[fptx_pkg::CTRL_TRUNC_BIT])
      rc = fptx_pkg::RC_TRUNC;
    next_res  = res;
    next_rgr  = rgr;
    next_rtok = rtok;
    next_opst = opst;
    flag_set  = 24'h0;
    if (go) begin
      img = be ? swap(gr, op == fptx_pkg::OP_SETF_D) : gr;
      unique case (op)
        fptx_pkg::OP_SETF_SIG: next_res = {1'b0, fptx_pkg::EXP_INT, gr};
        fptx_pkg::OP_SETF_EXP: next_res = {gr[17], gr[16:0], 64'h8000_0000_0000_0000};
        fptx_pkg::OP_SETF_S:   next_res = to_reg(img, 1'b0);
        fptx_pkg::OP_SETF_D:   next_res = to_reg(img, 1'b1);
        fptx_pkg::OP_CVT_XF:   // Exact, unnormalised, sign carried
          next_res = {gr[63], fptx_pkg::EXP_INT, gr[63] ? 64'(-gr) : gr};
        default: ;
      endcase
      if (!op[3] && !op[2] && gr_tok)               // Token
        next_res = {1'b0, fptx_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE, 64'h0};
      next_rtok = 1'b0;
      if (!arith && op[2]) begin
        unique case (op)
          fptx_pkg::OP_GETF_SIG: next_rgr = fr[63:0];
          fptx_pkg::OP_GETF_EXP: next_rgr = {46'h0, fr[81:64]};
          fptx_pkg::OP_GETF_S:   next_rgr = to_mem(fr, 1'b0);
          default:               next_rgr = to_mem(fr, 1'b1);
        endcase
        if (be && (op == fptx_pkg::OP_GETF_S || op == fptx_pkg::OP_GETF_D))
          next_rgr = swap(next_rgr, op == fptx_pkg::OP_GETF_D);
        if (fr == {1'b0, fptx_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE, 64'h0}) begin
          next_rtok = 1'b1;
          next_rgr  = (op == fptx_pkg::OP_GETF_EXP) ? {47'h0, fptx_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE} : 64'h0;
        end
      end
      // Raised flags recorded in the chosen field only
      if (upd && !bad)
        flag_set[fptx_pkg::FLAG_W*sel +: fptx_pkg::FLAG_W] = ctrl[fptx_pkg::CTRL_RAISE_LSB +: 6];
      // Applied controls; trap-disable forces all traps off
      next_opst = {sel, bad, upd & ~bad,
                   fld[fptx_pkg::SF_TD_BIT] ? 6'h3f : traps, rc, ew, pr};
    end
    next_flags = (flags & ~flag_clr) | flag_set;    // Set wins over clear
  end

  // Register results and flags
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      res   <= 82'h0;
      rgr   <= 64'h0;
      rtok  <= 1'b0;
      opst  <= 16'h0;
      flags <= 24'h0;
    end else begin
      res   <= next_res;
      rgr   <= next_rgr;
      rtok  <= next_rtok;
      opst  <= next_opst;
      flags <= next_flags;
    end
  end
endmodule : fptx_core
`default_nettype wire

/* File: logic/fptx_pkg.sv */
`default_nettype none
package fptx_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] ADR_CTRL   = 6'h00;
  localparam logic [5:0] ADR_GR_LO  = 6'h04;
  localparam logic [5:0] ADR_GR_HI  = 6'h08;
  localparam logic [5:0] ADR_FR_LO  = 6'h0c;
  localparam logic [5:0] ADR_FR_HI  = 6'h10;
  localparam logic [5:0] ADR_FR_SE  = 6'h14;
  localparam logic [5:0] ADR_SF     = 6'h18;
  localparam logic [5:0] ADR_TRAPS  = 6'h1c;
  localparam logic [5:0] ADR_FLAGS  = 6'h20;
  localparam logic [5:0] ADR_RES_LO = 6'h24;
  localparam logic [5:0] ADR_RES_HI = 6'h28;
  localparam logic [5:0] ADR_RES_SE = 6'h2c;
  localparam logic [5:0] ADR_OPSTAT = 6'h30;
  // ==========================================================
  // Control word fields
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_SF_LSB    = 4;
  localparam int CTRL_PC_LSB    = 6;
  localparam int CTRL_BE_BIT    = 8;
  localparam int CTRL_NAT_BIT   = 9;
  localparam int CTRL_PAR_BIT   = 10;
  localparam int CTRL_TRUNC_BIT = 11;
  localparam int CTRL_GO_BIT    = 15;
  localparam int CTRL_RAISE_LSB = 16;
  // Status field layout, 8 bits per field
  localparam int SF_RC_LSB = 0;
  localparam int SF_PC_LSB = 2;
  localparam int SF_WRE_BIT = 4;
  localparam int SF_TD_BIT  = 5;
  localparam int FLAG_W     = 6;
  // ==========================================================
  // Reset values and encodings
  localparam logic [31:0] SF_RST    = 32'h0000_0000;
  localparam logic [5:0]  TRAPS_RST = 6'h3f;
  localparam logic [1:0]  PC_NONE = 2'h0, PC_SGL = 2'h1, PC_DBL = 2'h2;
  localparam logic [1:0]  PR_SGL = 2'h0, PR_RSV = 2'h1, PR_DBL = 2'h2, PR_EXT = 2'h3;
  localparam logic [1:0]  EW_8 = 2'h0, EW_11 = 2'h1, EW_15 = 2'h2, EW_17 = 2'h3;
  localparam logic [1:0]  RC_TRUNC = 2'h3;
  localparam logic [16:0] EXP_INT    = 17'h1003e;
  localparam logic [16:0] EXP_FP_DEFERRED_EXCEPTION_VALUE = 17'h1fffe;
  localparam logic [16:0] EXP_INF    = 17'h1ffff;
  localparam logic [16:0] ADJ_SGL    = 17'h0ff80;
  localparam logic [16:0] ADJ_DBL    = 17'h0fc00;
  // Operation codes
  typedef enum logic [3:0] {
    OP_SETF_SIG = 4'h0, OP_SETF_EXP = 4'h1, OP_SETF_S = 4'h2, OP_SETF_D = 4'h3,
    OP_GETF_SIG = 4'h4, OP_GETF_EXP = 4'h5, OP_GETF_S = 4'h6, OP_GETF_D = 4'h7,
    OP_FMA = 4'h8, OP_FMS = 4'h9, OP_FNMA = 4'ha, OP_RCPA = 4'hb,
    OP_RSQRTA = 4'hc, OP_CMPMM = 4'hd, OP_CVT_FX = 4'he, OP_CVT_XF = 4'hf
  } fptx_op_t;
endpackage : fptx_pkg
`default_nettype wire

/* File: bench/fptx_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// Port watcher
module fptx_chk (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [5:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic        wb_ack_out,
  input  wire logic [31:0] wb_dat_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic [31:0] sf_q, next_sf_q;      // Shadow of status fields
  logic [5:0]  tr_q, next_tr_q;      // Shadow of global traps
  logic [5:0]  gtr_q, next_gtr_q;    // Traps expected at last go
  logic [1:0]  gs_q, next_gs_q;      // Selector at last go
  logic        ar_q, next_ar_q;      // Last go was arithmetic other than OP_CVT_XF
  logic        wa;
  logic        ra;
  // Next shadow values; only full-word writes are tracked
  always_comb begin
    wa = wb_ack_out && wb_we_in && wb_sel_in == 4'hf;
    ra = wb_ack_out && !wb_we_in;
    next_sf_q = sf_q;
    next_tr_q = tr_q;
    next_gtr_q = gtr_q;
    next_gs_q = gs_q;
    next_ar_q = ar_q;
    if (wa && wb_adr_in == fptx_pkg::ADR_SF) next_sf_q = wb_dat_in;
    if (wa && wb_adr_in == fptx_pkg::ADR_TRAPS) next_tr_q = wb_dat_in[5:0];
    if (wa && wb_adr_in == fptx_pkg::ADR_CTRL && wb_dat_in[15]) begin
      next_gs_q = wb_dat_in[5:4];
      next_ar_q = wb_dat_in[3:0] >= 4'h8 && wb_dat_in[3:0] <= 4'he;
      // Main field never disables, its bit is reserved
      next_gtr_q = (wb_dat_in[5:4] != 2'h0 && sf_q[{wb_dat_in[5:4], 3'h5}]) ? 6'h3f : tr_q;
    end
  end
  // Register the shadows
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sf_q <= fptx_pkg::SF_RST;
      tr_q <= fptx_pkg::TRAPS_RST;
      gtr_q <= 6'h00;
      gs_q <= 2'h0;
      ar_q <= 1'b0;
    end else begin
      sf_q <= next_sf_q;
      tr_q <= next_tr_q;
      gtr_q <= next_gtr_q;
      gs_q <= next_gs_q;
      ar_q <= next_ar_q;
    end
  end
  property p_ack_next; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_out |-> wb_dat_out == 32'h0000_0000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_td_main; ra && wb_adr_in == fptx_pkg::ADR_SF |-> !wb_dat_out[5]; endproperty
  a_td_main: assert property (p_td_main) else $error("main trap disable read 1");
  property p_go_zero; ra && wb_adr_in == fptx_pkg::ADR_CTRL |-> !wb_dat_out[15]; endproperty
  a_go_zero: assert property (p_go_zero) else $error("go bit read back");
  property p_sel; ra && wb_adr_in == fptx_pkg::ADR_OPSTAT && ar_q |-> wb_dat_out[15:14] == gs_q; endproperty
  a_sel: assert property (p_sel) else $error("wrong status field used");
  property p_traps; ra && wb_adr_in == fptx_pkg::ADR_OPSTAT && ar_q |-> wb_dat_out[11:6] == gtr_q; endproperty
  a_traps: assert property (p_traps) else $error("wrong effective traps");
  property p_unmap; ra && wb_adr_in > fptx_pkg::ADR_OPSTAT |-> wb_dat_out == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : fptx_chk
`default_nettype wire

/* File: bench/fptx_wbm.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// Pipeline stand-in issuing classic bus cycles
module fptx_wbm (
  input  wire logic        ref_clk_in,
  input  wire logic        wb_ack_in,
  input  wire logic [31:0] wb_dat_in,
  output var  logic        wb_cyc_out,
  output var  logic        wb_stb_out,
  output var  logic        wb_we_out,
  output var  logic [5:0]  wb_adr_out,
  output var  logic [3:0]  wb_sel_out,
  output var  logic [31:0] wb_dat_out
);
  // Idle bus from time zero
  initial begin
    {wb_cyc_out, wb_stb_out, wb_we_out} = 3'h0;
    wb_adr_out = 6'h00;
    wb_sel_out = 4'h0;
    wb_dat_out = 32'h0000_0000;
  end
  // One cycle, held until ack is seen at an edge; only the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk_in);
    {wb_cyc_out, wb_stb_out, wb_we_out} <= {2'h3, w};
    wb_adr_out <= a;
    wb_sel_out <= 4'hf;
    wb_dat_out <= d;
    do begin
      @(posedge ref_clk_in);
    end while (wb_ack_in !== 1'b1);
    q = wb_dat_in;
    {wb_cyc_out, wb_stb_out} <= 2'h0;
  endtask : xfer
endmodule : fptx_wbm
`default_nettype wire

/* File: bench/fptx_core_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module fptx_core_bench;
  logic        ref_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        cyc, stb, we, ack;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr, fe;
  int          err_total = 0;
  int          compares = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  fptx_core fptx_core_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw),
    .wb_ack_out(ack), .wb_dat_out(dr));
  fptx_wbm fptx_wbm_i (.ref_clk_in(ref_clk_in), .wb_ack_in(ack), .wb_dat_in(dr),
    .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we), .wb_adr_out(adr),
    .wb_sel_out(sel), .wb_dat_out(dw));
  // ==========
  // Helpers
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("FAIL t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    fptx_wbm_i.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    fptx_wbm_i.xfer(1'b0, a, 32'h0, x);
    check(x & m, e);
  endtask : rd
  // Start an op; results land two cycles after ack
  task automatic op(input logic [3:0] o, input logic [31:0] x);
    wr(fptx_pkg::ADR_CTRL, x | 32'h0000_8000 | {28'h0, o});
    repeat (2) @(posedge ref_clk_in);
  endtask : op
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Field-1 cases: control, field byte, mask, expected status
  logic [11:0] tc [11] = '{12'h058, 12'h098, 12'h058, 12'h018, 12'h018, 12'h01b,
                           12'h418, 12'h01e, 12'h81e, 12'h018, 12'h41f};
  logic [7:0]  ts [11] = '{8'h00, 8'h00, 8'h10, 8'h0c, 8'h18, 8'h00,
                           8'h1c, 8'h01, 8'h01, 8'h04, 8'h00};
  logic [15:0] tm [11] = '{16'hf, 16'hf, 16'hf, 16'hf, 16'hf, 16'hf,
                           16'hf, 16'h30, 16'h30, 16'h2000, 16'h2000};
  logic [15:0] te [11] = '{16'h0, 16'h6, 16'hc, 16'hb, 16'he, 16'hf,
                           16'h0, 16'h10, 16'h30, 16'h2000, 16'h2000};
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    err_total++;
    print_verdict();
  end
  // ==========
  // Tests
  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rd(fptx_pkg::ADR_TRAPS, 32'h3f, 32'(fptx_pkg::TRAPS_RST));
    wr(6'h3c, 32'hffff_ffff);
    rd(6'h3c, '1, 32'h0);
    $display("reset and map done");
    wr(fptx_pkg::ADR_TRAPS, 32'h15);
    wr(fptx_pkg::ADR_SF, 32'h2020_2020);
    rd(fptx_pkg::ADR_SF, '1, 32'h2020_2000);
    fe = 32'h0;
    for (int s = 0; s < 4; s++) begin
      op(fptx_pkg::OP_FMA, {10'h0, 6'(1 << s), 10'h0, 2'(s), 4'h0});
      fe |= 32'(1 << s) << (6 * s);
      rd(fptx_pkg::ADR_OPSTAT, 32'hcfc0, {16'h0, 2'(s), 2'h0, (s == 0) ? 6'h15 : 6'h3f, 6'h0});
    end
    rd(fptx_pkg::ADR_FLAGS, '1, fe);
    wr(fptx_pkg::ADR_FLAGS, 32'hffff_ffff);
    op(fptx_pkg::OP_CVT_XF, 32'h003f_0020);
    op(fptx_pkg::OP_SETF_SIG, 32'h003f_0020);
    rd(fptx_pkg::ADR_FLAGS, '1, 32'h0);
    $display("status fields done");
    for (int i = 0; i < 11; i++) begin
      wr(fptx_pkg::ADR_SF, {16'h0, ts[i], 8'h0});
      op(tc[i][3:0], {20'h0, tc[i]});
      rd(fptx_pkg::ADR_OPSTAT, {16'h0, tm[i]}, {16'h0, te[i]});
    end
    $display("precision done");
    wr(fptx_pkg::ADR_GR_LO, 32'h89ab_cdef);
    wr(fptx_pkg::ADR_GR_HI, 32'h0123_4567);
    op(fptx_pkg::OP_SETF_SIG, 32'h0);
    rd(fptx_pkg::ADR_RES_SE, 32'h3ffff, 32'(fptx_pkg::EXP_INT));
    wr(fptx_pkg::ADR_GR_LO, 32'h0002_0005);
    op(fptx_pkg::OP_SETF_EXP, 32'h0);
    rd(fptx_pkg::ADR_RES_SE, 32'h3ffff, 32'h0002_0005);
    wr(fptx_pkg::ADR_FR_SE, 32'h0004_0000);
    op(fptx_pkg::OP_SETF_S, 32'h0);
    rd(fptx_pkg::ADR_RES_SE, 32'h3ffff, 32'(fptx_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE));
    wr(fptx_pkg::ADR_FR_SE, 32'(fptx_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE));
    op(fptx_pkg::OP_GETF_EXP, 32'h0);
    rd(fptx_pkg::ADR_RES_SE, 32'h40000, 32'h40000);
    rd(fptx_pkg::ADR_RES_LO, '1, 32'(fptx_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE));
    wr(fptx_pkg::ADR_FR_SE, 32'h0002_0005);
    wr(fptx_pkg::ADR_FR_LO, 32'h5566_7788);
    wr(fptx_pkg::ADR_FR_HI, 32'h1122_3344);
    op(fptx_pkg::OP_GETF_SIG, 32'h0);
    rd(fptx_pkg::ADR_RES_HI, '1, 32'h1122_3344);
    rd(fptx_pkg::ADR_RES_SE, 32'h40000, 32'h0);
    op(fptx_pkg::OP_GETF_EXP, 32'h0);
    rd(fptx_pkg::ADR_RES_LO, '1, 32'h0002_0005);
    $display("transfers done");
    wr(fptx_pkg::ADR_GR_HI, 32'h0);
    for (int b = 0; b < 2; b++) begin
      wr(fptx_pkg::ADR_GR_LO, b ? 32'h0000_803f : 32'h3f80_0000);
      op(fptx_pkg::OP_SETF_S, 32'(b) << 8);
      rd(fptx_pkg::ADR_RES_SE, 32'h3ffff, 32'(17'h7f + fptx_pkg::ADJ_SGL));
      wr(fptx_pkg::ADR_FR_SE, 32'h0000_ffff);
      wr(fptx_pkg::ADR_FR_HI, 32'h8000_0000);
      wr(fptx_pkg::ADR_FR_LO, 32'h0);
      op(fptx_pkg::OP_GETF_D, 32'(b) << 8);
      rd(fptx_pkg::ADR_RES_LO, '1, b ? 32'h0000_f03f : 32'h0);
      rd(fptx_pkg::ADR_RES_HI, '1, b ? 32'h0 : 32'h3ff0_0000);
    end
    $display("byte order done");
    print_verdict();
  end
endmodule : fptx_core_bench
bind fptx_core fptx_chk fptx_chk_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
  .wb_dat_out(wb_dat_out));
`default_nettype wire
